// *** ctu_regs.vh ***
// Purpose: constants for the counter timer interrupt unit
// Assumes: AHB-Lite word registers, 40 MHz clock
// Notes:   included by the top module and the testbench
`ifndef CTU_REGS_VH
`define CTU_REGS_VH
// register byte offsets
`define CTU_OFF_CMD      12'h000
`define CTU_OFF_ACC      12'h004
`define CTU_OFF_STATUS   12'h008
`define CTU_OFF_COUNT    12'h00C
// instruction prefix and function codes
`define CTU_PREFIX       8'h68
`define CTU_FN_HALT      8'h00
`define CTU_FN_STEP      8'h01
`define CTU_FN_PW2       8'h02
`define CTU_FN_EV2       8'h03
`define CTU_FN_PW1       8'h04
`define CTU_FN_EV1       8'h05
`define CTU_FN_LOAD      8'h06
`define CTU_FN_TIMER     8'h07
`define CTU_FN_READ      8'h08
`define CTU_FN_TOGGLE    8'h09
`define CTU_FN_XIE       8'h0A
`define CTU_FN_XID       8'h0B
`define CTU_FN_CIE       8'h0C
`define CTU_FN_CID       8'h0D
`define CTU_FN_BCI       8'h3E
`define CTU_FN_BXI       8'h3F
// mode codes
`define CTU_MODE_OFF     3'h0
`define CTU_MODE_TIMER   3'h1
`define CTU_MODE_EV1     3'h2
`define CTU_MODE_EV2     3'h3
`define CTU_MODE_PW1     3'h4
`define CTU_MODE_PW2     3'h5
// instruction length in machine cycles
`define CTU_INSTR_CYCLES 2'h3
// prescaler divide ratio minus one
`define CTU_PRESCALE_TOP 5'h1F
// status bit positions
`define CTU_ST_IRQ       0
`define CTU_ST_CIE       1
`define CTU_ST_XIE       2
`define CTU_ST_IE        3
`define CTU_ST_TOG       4
`define CTU_ST_Q         5
`define CTU_ST_BUSY      6
`define CTU_ST_BRANCH    7
`define CTU_ST_MODE_LO   8
`define CTU_ST_MODE_HI   10
`define CTU_ST_SVC_C     11
`define CTU_ST_SVC_X     12
`endif

// *** ctu_edge.v ***
// Purpose: two-flop synchroniser with edge pulses
// Assumes: async input, one clock
// Notes:   first flop is read only by the second
`timescale 1ns/10ps
module ctu_edge (
   input  wire clk,
   input  wire reset,
   input  wire din,
   output reg  level,
   output wire rise,
   output wire fall
);
   reg meta;
   reg prev;
   // synchronise then delay for edge detection
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         meta  <= 1'b1;
         level <= 1'b1;
         prev  <= 1'b1;
      end else begin
         meta  <= din;
         level <= meta;
         prev  <= level;
      end
   end
   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule // ctu_edge

// *** ctu_top.v ***
// Purpose: 8-bit down counter, prescaler, toggle link and irq control
// Assumes: instructions arrive through an AHB-Lite command register
// Notes:   accumulator is a register standing in for the processor's
`timescale 1ns/10ps
`include "ctu_regs.vh"
// Summary of operation
// - prefix plus function byte, three cycles
// - preset load copies accumulator, zero gives 256
// - decrement per event, irq at zero
// - load also reloads buffer, presets prescaler to top, clears mode, irq
// - readback copies count, disturbs nothing
// - halt freezes count, clears mode
// - step down decrements once, in any mode
// - timer mode divides timing pulse by 32
// - at zero reload buffer unless mode off, keep counting
// - event modes count falling flag edges
// - pulse mode counts timing pulse while flag low
// - flag high ends pulse mode, latches irq
// - zero during pulse sets irq, continues
// - toggle link flips output leaving one
// - load, reset or taken counter branch disables link
// - external enable flip-flop gates external service
// - enable sets; reset sets all enables
// - counter irq latched until service or clear
// - counter disable keeps pending request
// - counter branch regardless of enables
// - external branch while pin low, short only
module ctu_top (
   input  wire        clk,
   input  wire        reset,
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        timing_pulse_a,
   input  wire        event_flag_input_one_n,
   input  wire        event_flag_input_two_n,
   input  wire        external_irq_n,
   input  wire        irq_service_ack,
   input  wire        common_ie_set,
   output reg         flag_q,
   output reg         counter_irq_out,
   output reg         external_irq_out
);
   // machine state
   reg [7:0]  count;
   reg [7:0]  reload;
   reg [4:0]  prescale;
   reg [2:0]  mode;
   reg        irq;
   reg        toggle_link;
   reg        counter_irq_enable;
   reg        external_irq_enable;
   reg        common_ie;
   reg [7:0]  acc;
   reg        branch_taken;
   reg        busy;
   reg [1:0]  cyc;
   reg [7:0]  fn;
   reg        svc_c;
   reg        svc_x;
   // bus phase registers
   reg        wr_pend;
   reg [11:0] wr_addr;
   // synchronised inputs
   wire tpa_lvl;
   wire tpa_rise;
   wire ef1_lvl;
   wire ef1_rise;
   wire ef1_fall;
   wire ef2_lvl;
   wire ef2_rise;
   wire ef2_fall;
   wire xint_lvl;
   ctu_edge u_tpa (
      .clk   (clk),
      .reset (reset),
      .din   (timing_pulse_a),
      .level (tpa_lvl),
      .rise  (tpa_rise),
      .fall  ()
   );
   ctu_edge u_ef1 (
      .clk   (clk),
      .reset (reset),
      .din   (event_flag_input_one_n),
      .level (ef1_lvl),
      .rise  (ef1_rise),
      .fall  (ef1_fall)
   );
   ctu_edge u_ef2 (
      .clk   (clk),
      .reset (reset),
      .din   (event_flag_input_two_n),
      .level (ef2_lvl),
      .rise  (ef2_rise),
      .fall  (ef2_fall)
   );
   ctu_edge u_xint (
      .clk   (clk),
      .reset (reset),
      .din   (external_irq_n),
      .level (xint_lvl),
      .rise  (),
      .fall  ()
   );
   // address and data phase decode
   wire bus_go  = hsel & hready & htrans[1];
   wire cmd_wr  = wr_pend & (wr_addr == `CTU_OFF_CMD);
   wire acc_wr  = wr_pend & (wr_addr == `CTU_OFF_ACC);
   wire cmd_ok  = cmd_wr & ~busy & (hwdata[15:8] == `CTU_PREFIX);
   // instruction completes on last machine cycle
   wire exec    = busy & (cyc == `CTU_INSTR_CYCLES - 2'h1);
   function is_fn;
      input [7:0] code;
      is_fn = exec & (fn == code);
   endfunction
   wire do_load = is_fn(`CTU_FN_LOAD);
   wire do_halt = is_fn(`CTU_FN_HALT);
   wire do_step = is_fn(`CTU_FN_STEP);
   wire do_read = is_fn(`CTU_FN_READ);
   wire bci_hit = is_fn(`CTU_FN_BCI) & irq;
   wire bxi_hit = is_fn(`CTU_FN_BXI) & ~xint_lvl;
   // clock event selection per mode
   wire pw_mode  = (mode == `CTU_MODE_PW1) | (mode == `CTU_MODE_PW2);
   wire pw_flag  = (mode == `CTU_MODE_PW1) ? ef1_lvl : ef2_lvl;
   wire pw_end   = ((mode == `CTU_MODE_PW1) & ef1_rise) |
                   ((mode == `CTU_MODE_PW2) & ef2_rise);
   wire pre_wrap = (prescale == 5'h00);
   reg  tick;
   always @* begin
      case (mode)
         `CTU_MODE_TIMER: tick = tpa_rise & pre_wrap;
         `CTU_MODE_EV1:   tick = ef1_fall;
         `CTU_MODE_EV2:   tick = ef2_fall;
         `CTU_MODE_PW1,
         `CTU_MODE_PW2:   tick = tpa_rise & ~pw_flag & ~pw_end;
         default:         tick = 1'b0;
      endcase
   end
   wire dec     = tick | do_step;
   wire hit_one = dec & (count == 8'h01);
   // instruction sequencer: fetch function, count machine cycles
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         busy <= 1'b0;
         cyc  <= 2'h0;
         fn   <= 8'h00;
      end else if (cmd_ok) begin
         busy <= 1'b1;
         cyc  <= 2'h0;
         fn   <= hwdata[7:0];
      end else if (busy) begin
         cyc  <= cyc + 2'h1;
         if (exec)
            busy <= 1'b0;
      end
   end
   // prescaler counts timing pulses in timer mode
   always @(posedge clk or posedge reset) begin
      if (reset)
         prescale <= `CTU_PRESCALE_TOP;
      else if (do_load)
         prescale <= `CTU_PRESCALE_TOP;
      else if ((mode == `CTU_MODE_TIMER) & tpa_rise)
         prescale <= prescale - 5'h01;
   end
   // counter, reload buffer and mode
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         count  <= 8'h00;
         reload <= 8'h00;
         mode   <= `CTU_MODE_OFF;
      end else if (do_load) begin
         count  <= acc;
         reload <= acc;
         mode   <= `CTU_MODE_OFF;
      end else begin
         if (dec) begin
            if (count == 8'h01 && mode != `CTU_MODE_OFF)
               count <= reload;
            else
               count <= count - 8'h01;
         end
         if (do_halt)
            mode <= `CTU_MODE_OFF;
         else if (pw_mode & pw_end)
            mode <= `CTU_MODE_OFF;
         else if (exec) begin
            case (fn)
               `CTU_FN_TIMER: mode <= `CTU_MODE_TIMER;
               `CTU_FN_EV1:   mode <= `CTU_MODE_EV1;
               `CTU_FN_EV2:   mode <= `CTU_MODE_EV2;
               `CTU_FN_PW1:   mode <= `CTU_MODE_PW1;
               `CTU_FN_PW2:   mode <= `CTU_MODE_PW2;
               default:       mode <= mode;
            endcase
         end
      end
   end
   // counter irq: set beats clear in same cycle
   always @(posedge clk or posedge reset) begin
      if (reset)
         irq <= 1'b0;
      else if (hit_one | (pw_mode & pw_end))
         irq <= 1'b1;
      else if (do_load | bci_hit | svc_c)
         irq <= 1'b0;
   end
   // toggle link and q flag
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         toggle_link <= 1'b0;
         flag_q      <= 1'b0;
      end else begin
         if (do_load | bci_hit)
            toggle_link <= 1'b0;
         else if (is_fn(`CTU_FN_TOGGLE))
            toggle_link <= 1'b1;
         if (toggle_link & hit_one)
            flag_q <= ~flag_q;
      end
   end
   // enable flip-flops, all set by reset
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         counter_irq_enable       <= 1'b1;
         external_irq_enable       <= 1'b1;
         common_ie <= 1'b1;
      end else begin
         if (is_fn(`CTU_FN_XIE))
            external_irq_enable <= 1'b1;
         else if (is_fn(`CTU_FN_XID))
            external_irq_enable <= 1'b0;
         if (is_fn(`CTU_FN_CIE))
            counter_irq_enable <= 1'b1;
         else if (is_fn(`CTU_FN_CID))
            counter_irq_enable <= 1'b0;
         if (common_ie_set)
            common_ie <= 1'b1;
         else if (svc_c | svc_x)
            common_ie <= 1'b0;
      end
   end
   // service requests, counter has priority
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         svc_c            <= 1'b0;
         svc_x            <= 1'b0;
         counter_irq_out  <= 1'b0;
         external_irq_out <= 1'b0;
      end else begin
         counter_irq_out  <= irq & counter_irq_enable & common_ie;
         external_irq_out <= ~xint_lvl & external_irq_enable & common_ie;
         svc_c <= irq_service_ack & counter_irq_out;
         svc_x <= irq_service_ack & ~counter_irq_out & external_irq_out;
      end
   end
   // accumulator and branch result
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         acc          <= 8'h00;
         branch_taken <= 1'b0;
      end else begin
         if (do_read)
            acc <= count;
         else if (acc_wr)
            acc <= hwdata[7:0];
         if (is_fn(`CTU_FN_BCI))
            branch_taken <= irq;
         else if (is_fn(`CTU_FN_BXI))
            branch_taken <= bxi_hit;
      end
   end
   // status word
   wire [31:0] status;
   assign status = {19'h00000, svc_x, svc_c, mode, branch_taken, busy, flag_q,
                    toggle_link, common_ie, external_irq_enable, counter_irq_enable, irq};
   // AHB-Lite slave, zero wait states
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 12'h000;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend   <= bus_go & hwrite;
         wr_addr   <= {haddr[11:2], 2'b00};
         if (bus_go & ~hwrite) begin
            case ({haddr[11:2], 2'b00})
               `CTU_OFF_CMD:    hrdata <= {16'h0000, `CTU_PREFIX, fn};
               `CTU_OFF_ACC:    hrdata <= {24'h000000, acc};
               `CTU_OFF_STATUS: hrdata <= status;
               `CTU_OFF_COUNT:  hrdata <= {16'h0000, reload, count};
               default:         hrdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // ctu_top

// *** ctu_monitor.sv ***
// Purpose: port checker for ctu_top
// Assumes: one clock, async active-high reset
// Notes:   bound from the testbench file
`timescale 1ns/10ps
module ctu_monitor (
   input wire        clk,
   input wire        reset,
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire        timing_pulse_a,
   input wire        event_flag_input_one_n,
   input wire        event_flag_input_two_n,
   input wire        external_irq_n,
   input wire        irq_service_ack,
   input wire        common_ie_set,
   input wire        flag_q,
   input wire        counter_irq_out,
   input wire        external_irq_out
);
   reg  [2:0] last_in;
   reg  [3:0] quiet;
   wire [2:0] now_in = {timing_pulse_a, event_flag_input_one_n, event_flag_input_two_n};
   wire       cause  = hsel | irq_service_ack | common_ie_set | (now_in != last_in);
   // counts cycles with no possible cause of a count event
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         last_in <= 3'h3;
         quiet   <= 4'h0;
      end else begin
         last_in <= now_in;
         quiet   <= cause ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_rdata_hold: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite))
      else $error("hrdata changed without a read");
   a_ext_pin: assert property (external_irq_out |->
      !$past(external_irq_n, 2) || !$past(external_irq_n, 3) || !$past(external_irq_n, 4))
      else $error("external irq out without pin low");
   a_ext_high: assert property (external_irq_n [*5] |=> !external_irq_out)
      else $error("external irq out with pin high");
   a_quiet_stable: assert property (quiet >= 4'h8 |-> $stable(flag_q) && $stable(counter_irq_out))
      else $error("output moved with no cause");
   a_cnt_ack: assert property (counter_irq_out && irq_service_ack |-> ##[1:3] !counter_irq_out)
      else $error("counter irq kept after service");
   a_ext_ack: assert property (external_irq_out && irq_service_ack && !counter_irq_out
      && !common_ie_set |-> ##[1:3] !external_irq_out)
      else $error("external irq kept after service");
endmodule // ctu_monitor

// *** ctu_far.sv ***
// Purpose: far-side pins: timing pulse, event flags, external request
// Assumes: driven just after rising clock edges
// Notes:   tasks are called from the testbench
`timescale 1ns/10ps
module ctu_far (
   input wire clk,
   output reg timing_pulse_a,
   output reg event_flag_input_one_n,
   output reg event_flag_input_two_n,
   output reg external_irq_n
);
   // idle levels
   initial begin
      timing_pulse_a = 1'b0;
      event_flag_input_one_n = 1'b1;
      event_flag_input_two_n = 1'b1;
      external_irq_n = 1'b1;
   end
   // n pulses, three cycles high and three low
   task pulses(input integer n);
      repeat (n) begin
         @(posedge clk);
         timing_pulse_a <= 1'b1;
         repeat (3) @(posedge clk);
         timing_pulse_a <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   // set one event flag and let it settle
   task flag(input sel, input lvl);
      begin
         @(posedge clk);
         if (sel)
            event_flag_input_two_n <= lvl;
         else
            event_flag_input_one_n <= lvl;
         repeat (3) @(posedge clk);
      end
   endtask
   // request level is held until released by the caller
   task ext(input lvl);
      begin
         @(posedge clk);
         external_irq_n <= lvl;
         repeat (6) @(posedge clk);
      end
   endtask
endmodule // ctu_far

// *** ctu_tb.sv ***
// Purpose: self-checking bench for ctu_top
// Assumes: 40 MHz clock, AHB-Lite single word transfers
// Notes:   far-side pins come from ctu_far
`timescale 1ns/10ps
`include "ctu_regs.vh"
module testbench;
   reg         clk, reset, hsel, hwrite, ack, cset;
   reg  [11:0] haddr;
   reg  [1:0]  htrans;
   reg  [2:0]  hsize;
   reg  [31:0] hwdata, r;
   reg  [31:0] rows [0:2];
   wire [31:0] hrdata;
   wire        hreadyout, hresp, pulse, flag_one_n, flag_two_n, ext_n, q, cirq, xirq;
   integer     err_total, num_checks, i;
   ctu_top i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timing_pulse_a(pulse),
      .event_flag_input_one_n(flag_one_n), .event_flag_input_two_n(flag_two_n),
      .external_irq_n(ext_n), .irq_service_ack(ack), .common_ie_set(cset), .flag_q(q),
      .counter_irq_out(cirq), .external_irq_out(xirq));
   ctu_far i_far (.clk(clk), .timing_pulse_a(pulse), .event_flag_input_one_n(flag_one_n),
      .event_flag_input_two_n(flag_two_n), .external_irq_n(ext_n));
   // clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task chk(input [31:0] seen, input [31:0] exp, input string what);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // one single transfer; read data lands in r
   task bus(input [11:0] a, input w, input [31:0] d);
      begin
         @(posedge clk);
         hsel   <= 1'b1;
         htrans <= 2'h2;
         haddr  <= a;
         hwrite <= w;
         hsize  <= 3'h2;
         @(posedge clk);
         while (hreadyout !== 1'b1) @(posedge clk);
         hsel   <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge clk);
         while (hreadyout !== 1'b1) @(posedge clk);
         r = hrdata;
      end
   endtask
   task cmd(input [7:0] fn);
      begin
         bus(`CTU_OFF_CMD, 1'b1, {16'h0, `CTU_PREFIX, fn});
         repeat (5) @(posedge clk);
      end
   endtask
   task ld(input [7:0] v);
      begin
         bus(`CTU_OFF_ACC, 1'b1, {24'h0, v});
         cmd(`CTU_FN_LOAD);
      end
   endtask
   // one-cycle pulse on service ack or common enable set
   task poke(input sel);
      begin
         @(posedge clk);
         if (sel)
            cset <= 1'b1;
         else
            ack <= 1'b1;
         @(posedge clk);
         ack  <= 1'b0;
         cset <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // watchdog, several times the expected run
   initial begin
      #400000;
      err_total = err_total + 1;
      final_report;
   end
   // main sequence
   initial begin
      err_total = 0;
      num_checks = 0;
      {hsel, hwrite, ack, cset, haddr, htrans, hsize, hwdata} = 0;
      reset = 1'b1;
      rows[0] = 32'h05_02_03_00;
      rows[1] = 32'h00_01_FF_00;
      rows[2] = 32'h01_01_00_01;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
      chk(r[10:0], 11'h00E, "reset status");
      bus(12'h010, 1'b0, 32'h0);
      chk(r, 32'h0, "unmapped");
      $display("reset test done");
      // rows: preset, software steps, count, irq
      for (i = 0; i < 3; i = i + 1) begin
         ld(rows[i][31:24]);
         repeat (rows[i][23:16]) cmd(`CTU_FN_STEP);
         cmd(`CTU_FN_READ);
         bus(`CTU_OFF_ACC, 1'b0, 32'h0);
         chk(r[7:0], rows[i][15:8], "readback");
         bus(`CTU_OFF_COUNT, 1'b0, 32'h0);
         chk(r[15:0], {rows[i][31:24], rows[i][15:8]}, "count");
         bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
         chk(r[0], rows[i][0], "zero irq");
      end
      $display("row tests done");
      ld(8'h02);
      cmd(`CTU_FN_TIMER);
      cmd(`CTU_FN_TOGGLE);
      i_far.pulses(32);
      bus(`CTU_OFF_COUNT, 1'b0, 32'h0);
      chk(r[7:0], 8'h01, "timer count");
      i_far.pulses(32);
      bus(`CTU_OFF_COUNT, 1'b0, 32'h0);
      chk({q, cirq, r[7:0]}, 10'h302, "timer reload");
      cmd(`CTU_FN_CID);
      bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
      chk({cirq, r[0]}, 2'b01, "disabled irq");
      cmd(`CTU_FN_CIE);
      poke(1'b0);
      bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
      chk({r[3], r[0]}, 2'b00, "counter serviced");
      poke(1'b1);
      ld(8'h07);
      bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
      chk(r[10:0], 11'h02E, "after load");
      cmd(`CTU_FN_TIMER);
      i_far.pulses(32);
      cmd(`CTU_FN_HALT);
      i_far.pulses(32);
      bus(`CTU_OFF_COUNT, 1'b0, 32'h0);
      chk(r[7:0], 8'h06, "halted count");
      $display("timer test done");
      for (i = 0; i < 2; i = i + 1) begin
         ld(8'h03);
         cmd(i ? `CTU_FN_EV2 : `CTU_FN_EV1);
         cmd(`CTU_FN_TOGGLE);
         repeat (3) begin
            i_far.flag(i[0], 1'b0);
            i_far.flag(i[0], 1'b1);
         end
         bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
         chk({r[10:8], r[0]}, {3'h2 + i[2:0], 1'b1}, "event irq");
         bus(`CTU_OFF_COUNT, 1'b0, 32'h0);
         chk(r[7:0], 8'h03, "event count");
         cmd(`CTU_FN_CID);
         cmd(`CTU_FN_BCI);
         bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
         chk({r[7], r[4], r[0]}, 3'b100, "branch");
         cmd(`CTU_FN_CIE);
      end
      $display("event test done");
      for (i = 0; i < 2; i = i + 1) begin
         ld(8'h0A);
         cmd(i ? `CTU_FN_PW2 : `CTU_FN_PW1);
         i_far.pulses(2);
         i_far.flag(i[0], 1'b0);
         i_far.pulses(4);
         i_far.flag(i[0], 1'b1);
         i_far.pulses(2);
         bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
         chk({r[10:8], r[0]}, 4'h1, "pulse end");
         bus(`CTU_OFF_COUNT, 1'b0, 32'h0);
         chk(r[7:0], 8'h06, "pulse count");
      end
      $display("pulse test done");
      cmd(`CTU_FN_BCI);
      cmd(`CTU_FN_XID);
      i_far.ext(1'b0);
      chk(xirq, 1'b0, "ext disabled");
      cmd(`CTU_FN_XIE);
      chk(xirq, 1'b1, "ext enabled");
      cmd(`CTU_FN_BXI);
      bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
      chk(r[7], 1'b1, "ext branch");
      poke(1'b0);
      chk(xirq, 1'b0, "ext serviced");
      poke(1'b1);
      chk(xirq, 1'b1, "common set");
      i_far.ext(1'b1);
      cmd(`CTU_FN_BXI);
      bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
      chk(r[7], 1'b0, "ext no branch");
      $display("external test done");
      // reset in mid-run clears link and q, sets enables
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      bus(`CTU_OFF_STATUS, 1'b0, 32'h0);
      chk({q, r[10:0]}, 12'h00E, "mid reset");
      bus(`CTU_OFF_COUNT, 1'b0, 32'h0);
      chk(r[15:0], 16'h0000, "mid reset count");
      $display("reset rerun done");
      final_report;
   end
endmodule // testbench
bind ctu_top ctu_monitor i_mon (.clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .timing_pulse_a(timing_pulse_a), .event_flag_input_one_n(event_flag_input_one_n),
   .event_flag_input_two_n(event_flag_input_two_n), .external_irq_n(external_irq_n),
   .irq_service_ack(irq_service_ack), .common_ie_set(common_ie_set), .flag_q(flag_q),
   .counter_irq_out(counter_irq_out), .external_irq_out(external_irq_out));
